/* File: include/tdt_pkg.sv */
// Constants and carrier types for the two-channel timer support block.
// Assumes a single 50 MHz operation clock and software-driven control bits.
// Notes on behaviour
// - Prescaled clock chosen by clock select field.
// - Select 110b counts fast oscillator clock.
// - External edges need enable, 101b, input.
// - Edge select field picks counted edge.
// - Fixed-period mode forbids external clock source.
// - C buffers A, D buffers B.
// - Capture copies old A/B into buffer.
// - Compare/PWM match loads A/B from buffer.
// - Sync/fixed-period loads on channel 0 A-match.
// - Complementary loads B0,A1,B1 on match/underflow.
// - Buffers still raise their match flags.
// - Linked write loads both counters.
// - Linked sync clear clears both counters.
// - Pin is timer output while disable bit 0.
// - Cutoff low sets all disable bits.
// - Outputs released within one to two clocks.
// - Cutoff edge raises interrupt request flag.
package tdt_pkg;

	localparam int CNT_W = 16;
	localparam int PRE_W = 5;
	localparam int NUM_PINS = 8;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	localparam logic [2:0] CKS_F1   = 3'h0;
	localparam logic [2:0] CKS_F2   = 3'h1;
	localparam logic [2:0] CKS_F4   = 3'h2;
	localparam logic [2:0] CKS_F8   = 3'h3;
	localparam logic [2:0] CKS_F32  = 3'h4;
	localparam logic [2:0] CKS_EXT  = 3'h5;
	localparam logic [2:0] CKS_FAST = 3'h6;

	localparam logic [PRE_W-1:0] PRE_MASK_F2  = 5'h01;
	localparam logic [PRE_W-1:0] PRE_MASK_F4  = 5'h03;
	localparam logic [PRE_W-1:0] PRE_MASK_F8  = 5'h07;
	localparam logic [PRE_W-1:0] PRE_MASK_F32 = 5'h1f;

	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h2;

	localparam logic [2:0] CLR_MATCH_A = 3'h1;
	localparam logic [2:0] CLR_MATCH_B = 3'h2;
	localparam logic [2:0] CLR_SYNC    = 3'h3;

	localparam logic [1:0] GR_A = 2'h0;
	localparam logic [1:0] GR_B = 2'h1;
	localparam logic [1:0] GR_C = 2'h2;
	localparam logic [1:0] GR_D = 2'h3;

	localparam logic [CNT_W-1:0]    CNT_RST = 16'h0000;
	localparam logic [CNT_W-1:0]    GR_RST  = 16'hffff;
	localparam logic [NUM_PINS-1:0] OD_ALL  = 8'hff;

	typedef enum logic [2:0] {
		MODE_TIMER = 3'b000,
		MODE_PWM   = 3'b001,
		MODE_RSYNC = 3'b011,
		MODE_COMP  = 3'b010,
		MODE_FIXED = 3'b110
	} tdt_mode_type;

	typedef struct packed {
		logic [2:0] clock_select_field;
		logic [1:0] ext_edge_select;
		logic [2:0] clear_source_select;
		logic       start;
		logic       buffer_c_enable;
		logic       buffer_d_enable;
	} tdt_chan_ctrl_type;

	typedef struct packed {
		logic cutoff_enable;
		logic cutoff_input_enable;
		logic cutoff_polarity_both;
		logic irq_polarity_select;
	} tdt_cutoff_ctrl_type;

endpackage

/* File: verilog/tdt_pin_edge.sv */
// Two-flop synchroniser with edge detection for one asynchronous pin.
// Assumes the pin holds each level for several clocks.
`timescale 1ns/1ps
module tdt_pin_edge
(
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic pin,
	output logic      level,
	output logic      rise,
	output logic      fall
);

	logic meta;
	logic sync;
	logic prev;

	// The first stage feeds only the second stage.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			meta <= 1'b1;
			sync <= 1'b1;
			prev <= 1'b1;
		end
		else
		begin
			meta <= pin;
			sync <= meta;
			prev <= sync;
		end
	end

	assign level = sync;
	assign rise  = sync & ~prev;
	assign fall  = ~sync & prev;

endmodule

/* File: verilog/tdt_core.sv */
// Count source selection, buffer transfer, synchronous preset/clear
// and forced pulse cutoff for a two-channel 16-bit timer.
// Assumes all control bits come from logic on ref_clk; pins are async.
`timescale 1ns/1ps
module tdt_core
(
	input  wire logic                               ref_clk,
	input  wire logic                               rst,
	input  wire logic                               ext_clock_pin,
	input  wire logic                               fast_osc_clock,
	input  wire logic                               cutoff_input_pin,
	input  tdt_pkg::tdt_chan_ctrl_type [1:0]        chan_ctrl,
	input  tdt_pkg::tdt_mode_type                   mode,
	input  tdt_pkg::tdt_cutoff_ctrl_type            cutoff_ctrl,
	input  wire logic                               counter_link_enable,
	input  wire logic                               ext_clock_enable,
	input  wire logic                               fast_osc_enable,
	input  wire logic                               clock_pin_direction,
	input  wire logic                               counter_wr,
	input  wire logic                               counter_wr_ch,
	input  wire logic [tdt_pkg::CNT_W-1:0]          counter_wr_data,
	input  wire logic                               gr_wr,
	input  wire logic                               gr_wr_ch,
	input  wire logic [1:0]                         gr_wr_sel,
	input  wire logic [tdt_pkg::CNT_W-1:0]          gr_wr_data,
	input  wire logic [1:0]                         capture_a,
	input  wire logic [1:0]                         capture_b,
	input  wire logic [1:0]                         flag_clear,
	input  wire logic                               od_wr,
	input  wire logic [tdt_pkg::NUM_PINS-1:0]       od_wr_data,
	input  wire logic                               irq_clear,
	output logic [tdt_pkg::CNT_W-1:0]               counter_ch0,
	output logic [tdt_pkg::CNT_W-1:0]               counter_ch1,
	output logic [1:0][tdt_pkg::CNT_W-1:0]          general_reg_a,
	output logic [1:0][tdt_pkg::CNT_W-1:0]          general_reg_b,
	output logic [1:0][tdt_pkg::CNT_W-1:0]          general_reg_c,
	output logic [1:0][tdt_pkg::CNT_W-1:0]          general_reg_d,
	output logic [1:0]                              match_flag_c,
	output logic [1:0]                              match_flag_d,
	output logic [tdt_pkg::NUM_PINS-1:0]            output_disable_reg,
	output logic [tdt_pkg::NUM_PINS-1:0]            timer_output_active,
	output logic                                    irq_request_flag
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic                      ext_rise;
	logic                      ext_fall;
	logic                      fast_rise;
	logic                      cut_level;
	logic                      cut_rise;
	logic                      cut_fall;
	logic [tdt_pkg::PRE_W-1:0] pre;
	logic [1:0][tdt_pkg::CNT_W-1:0] cnt;
	logic [1:0]                tick;
	logic [1:0]                ext_edge;
	logic [1:0]                evt_a;
	logic [1:0]                evt_b;
	logic [1:0]                evt_c;
	logic [1:0]                evt_d;
	logic [1:0]                clr_self;
	logic [1:0]                clr;
	logic [1:0]                load_a;
	logic [1:0]                load_b;
	logic                      underflow1;
	logic                      cut_hit;
	logic                      irq_evt;

	tdt_pin_edge u_ext
	(
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin     (ext_clock_pin),
		.level   (),
		.rise    (ext_rise),
		.fall    (ext_fall)
	);

	// The fast clock is slower than ref_clk here, so it is sampled as a pin.
	tdt_pin_edge u_fast
	(
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin     (fast_osc_clock),
		.level   (),
		.rise    (fast_rise),
		.fall    ()
	);

	tdt_pin_edge u_cut
	(
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin     (cutoff_input_pin),
		.level   (cut_level),
		.rise    (cut_rise),
		.fall    (cut_fall)
	);

	// ----------------------------------------------------------------
	// Count source selection
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			pre <= '0;
		else
			pre <= pre + 1'b1;
	end

	assign underflow1 = (mode == tdt_pkg::MODE_COMP) & chan_ctrl[1].start & tick[1]
		& (cnt[1] == tdt_pkg::CNT_RST);

	genvar c;
	generate
		for (c = 0; c < 2; c++)
		begin : g_ch
			always_comb
			begin
				unique case (chan_ctrl[c].ext_edge_select)
					tdt_pkg::EDGE_RISE: ext_edge[c] = ext_rise;
					tdt_pkg::EDGE_FALL: ext_edge[c] = ext_fall;
					tdt_pkg::EDGE_BOTH: ext_edge[c] = ext_rise | ext_fall;
					default:            ext_edge[c] = 1'b0;
				endcase
			end

			always_comb
			begin
				unique case (chan_ctrl[c].clock_select_field)
					tdt_pkg::CKS_F1:  tick[c] = 1'b1;
					tdt_pkg::CKS_F2:  tick[c] = &(pre | ~tdt_pkg::PRE_MASK_F2);
					tdt_pkg::CKS_F4:  tick[c] = &(pre | ~tdt_pkg::PRE_MASK_F4);
					tdt_pkg::CKS_F8:  tick[c] = &(pre | ~tdt_pkg::PRE_MASK_F8);
					tdt_pkg::CKS_F32: tick[c] = &(pre | ~tdt_pkg::PRE_MASK_F32);
					tdt_pkg::CKS_EXT: tick[c] = ext_edge[c] & ext_clock_enable
						& ~clock_pin_direction & (mode != tdt_pkg::MODE_FIXED);
					tdt_pkg::CKS_FAST: tick[c] = fast_rise & fast_osc_enable;
					default:          tick[c] = 1'b0;
				endcase
			end

			// Compare events are qualified by a count tick so a stalled
			// counter does not fire the same match on every clock.
			assign evt_a[c] = chan_ctrl[c].start & tick[c] & (cnt[c] == general_reg_a[c]);
			assign evt_b[c] = chan_ctrl[c].start & tick[c] & (cnt[c] == general_reg_b[c]);
			assign evt_c[c] = chan_ctrl[c].start & tick[c] & (cnt[c] == general_reg_c[c]);
			assign evt_d[c] = chan_ctrl[c].start & tick[c] & (cnt[c] == general_reg_d[c]);

			assign clr_self[c] =
				((chan_ctrl[c].clear_source_select == tdt_pkg::CLR_MATCH_A) & evt_a[c])
				| ((chan_ctrl[c].clear_source_select == tdt_pkg::CLR_MATCH_B) & evt_b[c]);

			assign clr[c] = clr_self[c] | (counter_link_enable & clr_self[c^1]
				& (chan_ctrl[c].clear_source_select == tdt_pkg::CLR_SYNC));

			// ----------------------------------------------------------------
			// Counters
			// ----------------------------------------------------------------
			always_ff @(posedge ref_clk or posedge rst)
			begin
				if (rst)
					cnt[c] <= tdt_pkg::CNT_RST;
				else if (counter_wr & (counter_link_enable | (counter_wr_ch == c[0])))
					cnt[c] <= counter_wr_data;
				else if (clr[c])
					cnt[c] <= tdt_pkg::CNT_RST;
				else if (chan_ctrl[c].start & tick[c])
				begin
					if ((c == 1) && (mode == tdt_pkg::MODE_COMP))
						cnt[c] <= cnt[c] - 1'b1;
					else
						cnt[c] <= cnt[c] + 1'b1;
				end
			end

			// ----------------------------------------------------------------
			// General and buffer registers
			// ----------------------------------------------------------------
			// C/D act as buffers of A/B
			always_ff @(posedge ref_clk or posedge rst)
			begin
				if (rst)
				begin
					general_reg_a[c] <= tdt_pkg::GR_RST;
					general_reg_b[c] <= tdt_pkg::GR_RST;
					general_reg_c[c] <= tdt_pkg::GR_RST;
					general_reg_d[c] <= tdt_pkg::GR_RST;
				end
				else
				begin
					if (capture_a[c] & (mode == tdt_pkg::MODE_TIMER))
						general_reg_a[c] <= cnt[c];
					else if (load_a[c])
						general_reg_a[c] <= general_reg_c[c];
					else if (gr_wr & (gr_wr_ch == c[0]) & (gr_wr_sel == tdt_pkg::GR_A))
						general_reg_a[c] <= gr_wr_data;

					if (capture_b[c] & (mode == tdt_pkg::MODE_TIMER))
						general_reg_b[c] <= cnt[c];
					else if (load_b[c])
						general_reg_b[c] <= general_reg_d[c];
					else if (gr_wr & (gr_wr_ch == c[0]) & (gr_wr_sel == tdt_pkg::GR_B))
						general_reg_b[c] <= gr_wr_data;

					if (capture_a[c] & (mode == tdt_pkg::MODE_TIMER)
						& chan_ctrl[c].buffer_c_enable)
						general_reg_c[c] <= general_reg_a[c];
					else if (gr_wr & (gr_wr_ch == c[0]) & (gr_wr_sel == tdt_pkg::GR_C))
						general_reg_c[c] <= gr_wr_data;

					if (capture_b[c] & (mode == tdt_pkg::MODE_TIMER)
						& chan_ctrl[c].buffer_d_enable)
						general_reg_d[c] <= general_reg_b[c];
					else if (gr_wr & (gr_wr_ch == c[0]) & (gr_wr_sel == tdt_pkg::GR_D))
						general_reg_d[c] <= gr_wr_data;
				end
			end

			always_ff @(posedge ref_clk or posedge rst)
			begin
				if (rst)
				begin
					match_flag_c[c] <= 1'b0;
					match_flag_d[c] <= 1'b0;
				end
				else
				begin
					match_flag_c[c] <= evt_c[c] | (match_flag_c[c] & ~flag_clear[c]);
					match_flag_d[c] <= evt_d[c] | (match_flag_d[c] & ~flag_clear[c]);
				end
			end
		end
	endgenerate

	assign counter_ch0 = cnt[0];
	assign counter_ch1 = cnt[1];

	// ----------------------------------------------------------------
	// Buffer transfer timing per mode
	// ----------------------------------------------------------------
	always_comb
	begin
		load_a = 2'b00;
		load_b = 2'b00;
		unique case (mode)
			tdt_pkg::MODE_TIMER, tdt_pkg::MODE_PWM:
			begin
				load_a = evt_a & {chan_ctrl[1].buffer_c_enable, chan_ctrl[0].buffer_c_enable};
				load_b = evt_b & {chan_ctrl[1].buffer_d_enable, chan_ctrl[0].buffer_d_enable};
			end
			tdt_pkg::MODE_RSYNC, tdt_pkg::MODE_FIXED:
			begin
				load_a = {2{evt_a[0]}}
					& {chan_ctrl[1].buffer_c_enable, chan_ctrl[0].buffer_c_enable};
				load_b = {2{evt_a[0]}}
					& {chan_ctrl[1].buffer_d_enable, chan_ctrl[0].buffer_d_enable};
			end
			tdt_pkg::MODE_COMP:
			begin
				load_a[1] = (evt_a[0] | underflow1) & chan_ctrl[1].buffer_c_enable;
				load_b[0] = (evt_a[0] | underflow1) & chan_ctrl[0].buffer_d_enable;
				load_b[1] = (evt_a[0] | underflow1) & chan_ctrl[1].buffer_d_enable;
			end
			default:
			begin
				load_a = 2'b00;
				load_b = 2'b00;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Forced cutoff and interrupt request
	// ----------------------------------------------------------------
	assign cut_hit = cutoff_ctrl.cutoff_enable & cutoff_ctrl.cutoff_input_enable & ~cut_level;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			output_disable_reg <= tdt_pkg::OD_ALL;
		else if (cut_hit)
			output_disable_reg <= tdt_pkg::OD_ALL;
		else if (od_wr)
			output_disable_reg <= od_wr_data;
	end

	// The gate on the synchronised level releases pins one register
	// stage earlier than waiting for the disable bits themselves.
	// pins driven only when enabled
	assign timer_output_active = ~output_disable_reg & {tdt_pkg::NUM_PINS{~cut_hit}};

	assign irq_evt = cutoff_ctrl.cutoff_input_enable
		& (cutoff_ctrl.cutoff_polarity_both ? (cut_rise | cut_fall)
		: (cutoff_ctrl.irq_polarity_select ? cut_rise : cut_fall));

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			irq_request_flag <= 1'b0;
		else
			irq_request_flag <= irq_evt | (irq_request_flag & ~irq_clear);
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	chk_fast_gate: assert property (
		(chan_ctrl[0].clock_select_field == tdt_pkg::CKS_FAST) & ~fast_osc_enable |-> !tick[0])
		else $error("fast source counted while oscillator off");
	chk_ext_gate: assert property (
		(chan_ctrl[0].clock_select_field == tdt_pkg::CKS_EXT) & tick[0]
		|-> ext_clock_enable & !clock_pin_direction)
		else $error("external edge counted while not enabled");
	chk_fixed_noext: assert property (
		(mode == tdt_pkg::MODE_FIXED)
		& (chan_ctrl[0].clock_select_field == tdt_pkg::CKS_EXT) |-> !tick[0])
		else $error("external source used in fixed-period mode");
	chk_capture_buf: assert property (
		capture_a[0] & (mode == tdt_pkg::MODE_TIMER) & chan_ctrl[0].buffer_c_enable
		|=> general_reg_c[0] == $past(general_reg_a[0]))
		else $error("capture did not push old value into buffer");
	chk_compare_load: assert property (
		(mode == tdt_pkg::MODE_PWM) & evt_a[0] & chan_ctrl[0].buffer_c_enable
		|=> general_reg_a[0] == $past(general_reg_c[0]))
		else $error("match did not load register from buffer");
	chk_comp_load: assert property (
		(mode == tdt_pkg::MODE_COMP) & underflow1 & chan_ctrl[1].buffer_c_enable
		|=> general_reg_a[1] == $past(general_reg_c[1]))
		else $error("underflow did not load buffer in complementary mode");
	chk_flag_c: assert property (
		evt_c[0] |=> match_flag_c[0])
		else $error("buffer match flag not set");
	chk_link_write: assert property (
		counter_wr & counter_link_enable
		|=> (counter_ch0 == $past(counter_wr_data)) && (counter_ch1 == $past(counter_wr_data)))
		else $error("linked write did not reach both counters");
	chk_sync_clear: assert property (
		counter_link_enable & clr_self[0] & !counter_wr
		& (chan_ctrl[1].clear_source_select == tdt_pkg::CLR_SYNC)
		|=> counter_ch1 == tdt_pkg::CNT_RST)
		else $error("synchronous clear missed other counter");
	chk_cutoff_time: assert property (
		cutoff_ctrl.cutoff_enable & cutoff_ctrl.cutoff_input_enable & $fell(cutoff_input_pin)
		##1 (cutoff_ctrl.cutoff_enable & cutoff_ctrl.cutoff_input_enable & !cutoff_input_pin) [*2]
		|-> timer_output_active == '0)
		else $error("outputs not cut off within two clocks");
	chk_stay_off: assert property (
		(output_disable_reg == tdt_pkg::OD_ALL) & !od_wr |=> output_disable_reg == tdt_pkg::OD_ALL)
		else $error("output disable bits cleared without a write");
	chk_irq_set: assert property (
		irq_evt |=> irq_request_flag [*2] or (irq_request_flag ##1 1'b1))
		else $error("cutoff edge did not raise request flag");

	cov_cutoff: cover property (cut_hit ##1 output_disable_reg == tdt_pkg::OD_ALL);
	cov_comp_xfer: cover property ((mode == tdt_pkg::MODE_COMP) & underflow1);
	cov_sync_clear: cover property (counter_link_enable & clr[1] & !clr_self[1]);

endmodule

/* File: test/tdt_ext_src.sv */
// Far-side model: external count clock, fast clock and cutoff line.
// Assumes the bench changes its requests just after a falling edge.
`timescale 1ns/1ps
module tdt_ext_src
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       go,
	input  wire logic [7:0] pulse_cnt,
	input  wire logic       fast_on,
	input  wire logic       cut_low,
	output logic            ext_clock_pin,
	output logic            fast_osc_clock,
	output logic            cutoff_input_pin,
	output logic            busy
);
	logic [8:0] left;
	logic [1:0] hold;
	logic [1:0] fdiv;

	assign busy = (left != 9'h000);
	// The cutoff line is pulled up, so it idles high.
	assign cutoff_input_pin = ~cut_low;

	// The count clock idles high, the level the pin synchroniser assumes at reset.
	// three-clock levels
	always_ff @(posedge ref_clk or posedge rst)
		if (rst)
		begin
			left <= 9'h000;
			hold <= 2'h0;
			ext_clock_pin <= 1'b1;
		end
		else if (go)
			left <= {pulse_cnt, 1'b0};
		else if (busy && hold == 2'h2)
		begin
			hold <= 2'h0;
			left <= left - 9'h001;
			ext_clock_pin <= ~ext_clock_pin;
		end
		else if (busy)
			hold <= hold + 2'h1;

	// The fast clock stands still unless asked for, so edge counts are exact.
	always_ff @(posedge ref_clk or posedge rst)
		if (rst)
		begin
			fdiv <= 2'h0;
			fast_osc_clock <= 1'b0;
		end
		else if (!fast_on)
			fdiv <= 2'h0;
		else if (fdiv == 2'h2)
		begin
			fdiv <= 2'h0;
			fast_osc_clock <= ~fast_osc_clock;
		end
		else
			fdiv <= fdiv + 2'h1;
endmodule

/* File: test/dual_timer_source_buffer_cutoff_tb.sv */
// Self-checking bench for the two-channel timer support core.
// Assumes the far-side model supplies the pins; inputs change at falling edges.
`timescale 1ns/1ps
module dual_timer_source_buffer_cutoff_tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	tdt_pkg::tdt_chan_ctrl_type [1:0] cc = '0;
	tdt_pkg::tdt_mode_type md = tdt_pkg::MODE_TIMER;
	tdt_pkg::tdt_cutoff_ctrl_type co = '0;
	logic link = 0, ext_en = 0, fast_en = 0, pin_dir = 0, cnt_wr = 0, cnt_ch = 0;
	logic gr_wr = 0, gr_ch = 0, od_wr = 0, irq_clr = 0, go = 0, fast_on = 0, cut_low = 0;
	logic [1:0] gr_sel = 0, cap_a = 0, cap_b = 0, flag_clr = 0;
	logic [15:0] cnt_d = 0, gr_d = 0, c0, c1;
	logic [7:0] od_d = 0, od, act;
	logic ext_pin, fast_clk, cut_pin, busy, irq;
	logic [1:0][15:0] ga, gb, gc, gd;
	logic [1:0] mfc, mfd;
	int err_total = 0;
	int n_tests = 0;

	always #10 ref_clk = ~ref_clk;

	tdt_ext_src far_side
	(
		.ref_clk(ref_clk), .rst(rst), .go(go), .pulse_cnt(8'h04), .fast_on(fast_on),
		.cut_low(cut_low), .ext_clock_pin(ext_pin), .fast_osc_clock(fast_clk),
		.cutoff_input_pin(cut_pin), .busy(busy)
	);

	tdt_core uut
	(
		.ref_clk(ref_clk), .rst(rst), .ext_clock_pin(ext_pin), .fast_osc_clock(fast_clk),
		.cutoff_input_pin(cut_pin), .chan_ctrl(cc), .mode(md), .cutoff_ctrl(co),
		.counter_link_enable(link), .ext_clock_enable(ext_en), .fast_osc_enable(fast_en),
		.clock_pin_direction(pin_dir), .counter_wr(cnt_wr), .counter_wr_ch(cnt_ch),
		.counter_wr_data(cnt_d), .gr_wr(gr_wr), .gr_wr_ch(gr_ch), .gr_wr_sel(gr_sel),
		.gr_wr_data(gr_d), .capture_a(cap_a), .capture_b(cap_b), .flag_clear(flag_clr),
		.od_wr(od_wr), .od_wr_data(od_d), .irq_clear(irq_clr), .counter_ch0(c0),
		.counter_ch1(c1), .general_reg_a(ga), .general_reg_b(gb), .general_reg_c(gc),
		.general_reg_d(gd), .match_flag_c(mfc), .match_flag_d(mfd),
		.output_disable_reg(od), .timer_output_active(act), .irq_request_flag(irq)
	);

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic run(input logic [1:0] chs, input int n);
		cc[0].start = chs[0];
		cc[1].start = chs[1];
		cyc(n);
		cc[0].start = 1'b0;
		cc[1].start = 1'b0;
		cyc(1);
	endtask

	task automatic wcnt(input logic ch, input logic [15:0] d);
		cnt_ch = ch;
		cnt_d = d;
		cnt_wr = 1'b1;
		cyc(1);
		cnt_wr = 1'b0;
		// An idle edge after each write keeps a following write from
		// raising the strobe in the same step that lowered it.
		cyc(1);
	endtask

	task automatic wgr(input logic ch, input logic [1:0] sel, input logic [15:0] d);
		gr_ch = ch;
		gr_sel = sel;
		gr_d = d;
		gr_wr = 1'b1;
		cyc(1);
		gr_wr = 1'b0;
		cyc(1);
	endtask

	task automatic wod(input logic [7:0] d);
		od_d = d;
		od_wr = 1'b1;
		cyc(1);
		od_wr = 1'b0;
		cyc(1);
	endtask

	task automatic t_reset;
		chk(ga[1], tdt_pkg::GR_RST);
		chk(od, tdt_pkg::OD_ALL);
		chk(act, 8'h00);
	endtask

	// Any 64-cycle window holds exactly 64/div prescaler ticks, whatever the phase.
	task automatic t_prescale;
		logic [2:0] sel [5];
		sel = '{tdt_pkg::CKS_F1, tdt_pkg::CKS_F2, tdt_pkg::CKS_F4, tdt_pkg::CKS_F8,
			tdt_pkg::CKS_F32};
		for (int i = 0; i < 5; i++)
		begin
			wcnt(1'b0, 16'h0000);
			cc[0].clock_select_field = sel[i];
			run(2'b01, 64);
			chk(c0, 16'(64 >> ((i == 4) ? 5 : i)));
		end
	endtask

	task automatic t_ext;
		cc[0].clock_select_field = tdt_pkg::CKS_EXT;
		// Pass 6 uses the unassigned edge code, which must count nothing.
		for (int i = 0; i < 7; i++)
		begin
			cc[0].ext_edge_select = (i == 6) ? 2'h3 : (i < 3) ? 2'(i) : tdt_pkg::EDGE_RISE;
			ext_en = (i != 3);
			pin_dir = (i == 4);
			md = (i == 5) ? tdt_pkg::MODE_FIXED : tdt_pkg::MODE_TIMER;
			wcnt(1'b0, 16'h0000);
			cc[0].start = 1'b1;
			go = 1'b1;
			cyc(1);
			go = 1'b0;
			for (int k = 0; k < 100 && busy; k++)
				cyc(1);
			run(2'b01, 6);
			chk(c0, (i == 2) ? 16'h0008 : (i < 3) ? 16'h0004 : 16'h0000);
		end
		md = tdt_pkg::MODE_TIMER;
	endtask

	task automatic t_fast;
		for (int i = 0; i < 2; i++)
		begin
			fast_en = (i == 0);
			wcnt(1'b0, 16'h0000);
			cc[0].clock_select_field = tdt_pkg::CKS_FAST;
			cc[0].start = 1'b1;
			fast_on = 1'b1;
			cyc(60);
			fast_on = 1'b0;
			run(2'b01, 5);
			chk(c0, (i == 0) ? 16'h000a : 16'h0000);
		end
		cc = '0;
	endtask

	task automatic t_link;
		link = 1'b1;
		wcnt(1'b1, 16'h1234);
		chk(c0, 16'h1234);
		link = 1'b0;
		wcnt(1'b1, 16'h0042);
		chk(c0, 16'h1234);
		chk(c1, 16'h0042);
	endtask

	task automatic t_sync;
		md = tdt_pkg::MODE_RSYNC;
		link = 1'b1;
		wcnt(1'b0, 16'h0000);
		wgr(1'b0, tdt_pkg::GR_A, 16'h0009);
		wgr(1'b1, tdt_pkg::GR_C, 16'h0055);
		cc[1].buffer_c_enable = 1'b1;
		cc[0].clear_source_select = tdt_pkg::CLR_MATCH_A;
		cc[1].clear_source_select = tdt_pkg::CLR_SYNC;
		run(2'b11, 12);
		chk(c0, 16'h0002);
		chk(c1, 16'h0002);
		chk(ga[1], 16'h0055);
		chk(ga[0], 16'h0009);
		cc = '0;
		link = 1'b0;
	endtask

	task automatic t_pwm;
		md = tdt_pkg::MODE_PWM;
		wcnt(1'b0, 16'h0000);
		wgr(1'b0, tdt_pkg::GR_A, 16'h0005);
		wgr(1'b0, tdt_pkg::GR_C, 16'h0020);
		wgr(1'b0, tdt_pkg::GR_D, 16'h0025);
		flag_clr = 2'b11;
		cyc(1);
		flag_clr = 2'b00;
		cc[0].buffer_c_enable = 1'b1;
		run(2'b01, 20);
		chk(ga[0], 16'h0020);
		chk(mfc[0], 1'b0);
		chk(mfd[0], 1'b0);
		run(2'b01, 20);
		chk(mfc[0], 1'b1);
		chk(mfd[0], 1'b1);
		cc = '0;
	endtask

	task automatic t_capture;
		md = tdt_pkg::MODE_TIMER;
		wcnt(1'b0, 16'h0abc);
		wgr(1'b0, tdt_pkg::GR_A, 16'h0011);
		wgr(1'b0, tdt_pkg::GR_B, 16'h0022);
		cc[0].buffer_c_enable = 1'b1;
		cc[0].buffer_d_enable = 1'b1;
		cap_a = 2'b01;
		cap_b = 2'b01;
		cyc(1);
		cap_a = 2'b00;
		cap_b = 2'b00;
		cyc(1);
		chk(ga[0], 16'h0abc);
		chk(gc[0], 16'h0011);
		chk(gb[0], 16'h0abc);
		chk(gd[0], 16'h0022);
		cc = '0;
	endtask

	task automatic t_comp;
		md = tdt_pkg::MODE_COMP;
		wcnt(1'b1, 16'h0000);
		wgr(1'b0, tdt_pkg::GR_D, 16'h0077);
		wgr(1'b1, tdt_pkg::GR_C, 16'h0066);
		cc[0].buffer_d_enable = 1'b1;
		cc[1].buffer_c_enable = 1'b1;
		run(2'b10, 1);
		chk(gb[0], 16'h0077);
		chk(ga[1], 16'h0066);
		cc = '0;
	endtask

	task automatic t_cutoff;
		co.cutoff_input_enable = 1'b1;
		cyc(1);
		co.cutoff_enable = 1'b1;
		wod(8'h00);
		chk(act, 8'hff);
		cut_low = 1'b1;
		cyc(2);
		chk(act, 8'h00);
		cyc(1);
		chk(od, tdt_pkg::OD_ALL);
		chk(irq, 1'b1);
		cut_low = 1'b0;
		cyc(6);
		chk(od, tdt_pkg::OD_ALL);
		wod(8'h00);
		chk(act, 8'hff);
		irq_clr = 1'b1;
		cyc(1);
		irq_clr = 1'b0;
		chk(irq, 1'b0);
		co.irq_polarity_select = 1'b1;
		cut_low = 1'b1;
		cyc(4);
		chk(irq, 1'b0);
		cut_low = 1'b0;
		cyc(4);
		chk(irq, 1'b1);
	endtask

	initial
	begin
		cyc(3);
		rst = 1'b0;
		t_reset();
		t_prescale();
		t_ext();
		t_fast();
		t_link();
		t_sync();
		t_pwm();
		t_capture();
		t_comp();
		t_cutoff();
		final_report();
	end

	// The whole run needs under two thousand cycles.
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		err_total++;
		final_report();
	end
endmodule
